// *** internal_error_mask_status.sv ***
// The placing of the registers and the APB register port were decided locally.
`include "interr_consts.svh"

module internal_error_mask_status (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        soft_reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rx_overflow_err,
    input  wire logic        cfg_to_tx_parity_err,
    input  wire logic        tx_to_cfg_parity_err,
    input  wire logic        tx_tlp_parity_err,
    input  wire logic        app_uncor_err,
    input  wire logic        config_load_error_flag,
    input  wire logic        lcrc_parity_err,
    input  wire logic        rx_to_cfg_parity_err,
    input  wire logic        rx_buf_in_parity_err,
    input  wire logic        retry_uncor_ecc_err,
    input  wire logic        rx_buf_uncor_ecc_err,
    input  wire logic        app_cor_err,
    input  wire logic        retry_cor_ecc_err,
    input  wire logic        rx_buf_cor_ecc_err,
    input  wire logic        tx_tlp_valid,
    output logic             tx_tlp_send,
    output logic             config_via_link_mode,
    output logic             uncor_internal_err,
    output logic             cor_internal_err,
    output logic             irq
);
    localparam int NUM_EVENTS = 15;

    typedef struct packed {
        interr_pkg::bus_state_t      bus;
        logic [31:0]                 rdata;
        logic                        slverr;
        logic                        link_mode;
        logic                        load_err_prev;
        logic [`IRQ_WIDTH-1:0]       irq_status;
        logic [`IRQ_WIDTH-1:0]       irq_mask;
        logic                        irq;
        logic                        uncor_out;
        logic                        cor_out;
        logic                        tlp_send;
    } top_state_t;

    top_state_t           state;
    top_state_t           next_state;
    logic [NUM_EVENTS-1:0] ev_raw;
    logic [NUM_EVENTS-1:0] ev;
    logic [31:0]          uncor_events;
    logic [31:0]          cor_events;
    logic [31:0]          uncor_status;
    logic [31:0]          uncor_mask;
    logic [31:0]          cor_status;
    logic [31:0]          cor_mask;
    logic                 uncor_fwd;
    logic                 cor_fwd;
    logic                 access;
    logic                 wr;
    logic                 load_err;
    logic                 load_rise;
    logic [`IRQ_WIDTH-1:0] irq_events;

    assign ev_raw = {rx_overflow_err, cfg_to_tx_parity_err, tx_to_cfg_parity_err,
                     tx_tlp_parity_err, app_uncor_err, config_load_error_flag,
                     lcrc_parity_err, rx_to_cfg_parity_err, rx_buf_in_parity_err,
                     retry_uncor_ecc_err, rx_buf_uncor_ecc_err, app_cor_err,
                     retry_cor_ecc_err, rx_buf_cor_ecc_err, tx_tlp_valid};

    // error sources come from other clock domains of the core
    sync_two_flop #(
        .WIDTH (NUM_EVENTS)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (ev_raw),
        .sync_out (ev)
    );

    assign load_err  = ev[9];
    assign load_rise = load_err & ~state.load_err_prev;

    always_comb begin
        uncor_events = 32'h00000000;
        uncor_events[`UNCOR_BIT_OVERFLOW]  = ev[14];
        uncor_events[`UNCOR_BIT_CFG_TX]    = ev[13];
        uncor_events[`UNCOR_BIT_TX_CFG]    = ev[12];
        uncor_events[`UNCOR_BIT_TX_TLP]    = ev[11];
        uncor_events[`UNCOR_BIT_APP]       = ev[10];
        uncor_events[`UNCOR_BIT_CFGLOAD]   = load_rise & state.link_mode;
        uncor_events[`UNCOR_BIT_LCRC]      = ev[8];
        uncor_events[`UNCOR_BIT_RX_CFG]    = ev[7];
        uncor_events[`UNCOR_BIT_RXBUF_IN]  = ev[6];
        uncor_events[`UNCOR_BIT_RETRY_ECC] = ev[5];
        uncor_events[`UNCOR_BIT_RXBUF_ECC] = ev[4];
        cor_events = 32'h00000000;
        cor_events[`COR_BIT_APP]       = ev[3];
        // level-sensitive here, unlike the edge-sensitive uncorrectable bit
        cor_events[`COR_BIT_CFGLOAD]   = load_err & state.link_mode;
        cor_events[`COR_BIT_RETRY_ECC] = ev[2];
        cor_events[`COR_BIT_RXBUF_ECC] = ev[1];
    end

    assign access = psel & penable & (state.bus == interr_pkg::bus_idle);
    assign wr     = access & pwrite;

    // hard reset clears sticky status and loads the mask reset value; soft reset does not reach them
    sticky_bank #(
        .STATUS_BITS (`UNCOR_STATUS_BITS),
        .MASK_WR     (`UNCOR_WR_BITS),
        .MASK_RESET  (`UNCOR_MASK_RESET)
    ) u_uncor (
        .pclk          (pclk),
        .sticky_resetn (presetn),
        .soft_reset    (soft_reset),
        .events        (uncor_events),
        .mask_we       (wr && paddr == `OFS_UNCOR_MASK),
        .status_we     (wr && paddr == `OFS_UNCOR_STATUS),
        .wdata         (pwdata),
        .status        (uncor_status),
        .mask          (uncor_mask),
        .forward       (uncor_fwd)
    );

    sticky_bank #(
        .STATUS_BITS (`COR_STATUS_BITS),
        .MASK_WR     (`COR_WR_BITS),
        .MASK_RESET  (`COR_MASK_RESET)
    ) u_cor (
        .pclk          (pclk),
        .sticky_resetn (presetn),
        .soft_reset    (soft_reset),
        .events        (cor_events),
        .mask_we       (wr && paddr == `OFS_COR_MASK),
        .status_we     (wr && paddr == `OFS_COR_STATUS),
        .wdata         (pwdata),
        .status        (cor_status),
        .mask          (cor_mask),
        .forward       (cor_fwd)
    );

    assign irq_events = {cor_fwd, uncor_fwd};

    always_comb begin
        next_state = state;
        next_state.load_err_prev = load_err;
        next_state.uncor_out = uncor_fwd;
        next_state.cor_out   = cor_fwd;
        // a corrupted outgoing TLP is never passed on
        next_state.tlp_send = ev[0] & ~ev[11];
        next_state.irq_status = (state.irq_status
                                 & ~((wr && paddr == `OFS_IRQ_STATUS) ? pwdata[`IRQ_WIDTH-1:0] : '0))
                                | irq_events;
        if (wr && paddr == `OFS_IRQ_MASK) begin
            next_state.irq_mask = pwdata[`IRQ_WIDTH-1:0];
        end
        if (wr && paddr == `OFS_LINK_MODE_CTRL) begin
            next_state.link_mode = pwdata[`LINK_MODE_BIT];
        end
        next_state.irq = |(next_state.irq_status & next_state.irq_mask);
        unique case (state.bus)
            interr_pkg::bus_idle: begin
                if (access) begin
                    next_state.bus    = interr_pkg::bus_answer;
                    next_state.slverr = 1'b0;
                    next_state.rdata  = 32'h00000000;
                    unique case (paddr)
                        `OFS_UNCOR_MASK:     next_state.rdata = uncor_mask | `UNCOR_MASK_RO_ONES;
                        `OFS_UNCOR_STATUS:   next_state.rdata = uncor_status;
                        `OFS_COR_MASK:       next_state.rdata = cor_mask | `COR_MASK_RO_ONES;
                        `OFS_COR_STATUS:     next_state.rdata = cor_status;
                        `OFS_LINK_MODE_CTRL: next_state.rdata = {31'h00000000, state.link_mode};
                        `OFS_IRQ_STATUS:     next_state.rdata = {30'h00000000, state.irq_status};
                        `OFS_IRQ_MASK:       next_state.rdata = {30'h00000000, state.irq_mask};
                        default:             next_state.slverr = 1'b1;
                    endcase
                    if (pwrite) begin
                        next_state.rdata = 32'h00000000;
                    end
                end
            end
            interr_pkg::bus_answer: begin
                next_state.bus    = interr_pkg::bus_idle;
                next_state.slverr = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign prdata               = state.rdata;
    assign pready               = state.bus == interr_pkg::bus_answer;
    assign pslverr              = state.slverr;
    assign config_via_link_mode = state.link_mode;
    assign uncor_internal_err   = state.uncor_out;
    assign cor_internal_err     = state.cor_out;
    assign irq                  = state.irq;
    assign tx_tlp_send          = state.tlp_send;
endmodule : internal_error_mask_status

// *** interr_consts.svh ***
`ifndef INTERR_CONSTS_SVH
`define INTERR_CONSTS_SVH

// register byte addresses
`define OFS_UNCOR_MASK      12'h000
`define OFS_UNCOR_STATUS    12'h004
`define OFS_COR_MASK        12'h008
`define OFS_COR_STATUS      12'h00C
`define OFS_LINK_MODE_CTRL  12'h010
`define OFS_IRQ_STATUS      12'h014
`define OFS_IRQ_MASK        12'h018

// uncorrectable layout
`define UNCOR_WR_BITS       32'h00000BBF
`define UNCOR_MASK_RESET    32'h000003DF
`define UNCOR_MASK_RO_ONES  32'h00000440
`define UNCOR_STATUS_BITS   32'h00000BFF
`define UNCOR_BIT_OVERFLOW  11
`define UNCOR_BIT_CFG_TX    9
`define UNCOR_BIT_TX_CFG    8
`define UNCOR_BIT_TX_TLP    7
`define UNCOR_BIT_APP       6
`define UNCOR_BIT_CFGLOAD   5
`define UNCOR_BIT_LCRC      4
`define UNCOR_BIT_RX_CFG    3
`define UNCOR_BIT_RXBUF_IN  2
`define UNCOR_BIT_RETRY_ECC 1
`define UNCOR_BIT_RXBUF_ECC 0

// correctable layout
`define COR_WR_BITS         32'h00000063
`define COR_MASK_RESET      32'h00000063
`define COR_MASK_RO_ONES    32'h00000080
`define COR_STATUS_BITS     32'h00000063
`define COR_BIT_APP         6
`define COR_BIT_CFGLOAD     5
`define COR_BIT_RETRY_ECC   1
`define COR_BIT_RXBUF_ECC   0

// interrupt status: bit 0 uncorrectable forwarded, bit 1 correctable forwarded
`define IRQ_BIT_UNCOR       0
`define IRQ_BIT_COR         1
`define IRQ_WIDTH           2
`define LINK_MODE_BIT       0

`endif

// *** interr_pkg.sv ***
package interr_pkg;
    typedef logic [31:0] word_t;
    typedef enum logic [0:0] {
        bus_idle   = 1'b0,
        bus_answer = 1'b1
    } bus_state_t;
endpackage : interr_pkg

// *** sync_two_flop.sv ***
module sync_two_flop #(
    parameter int WIDTH = 1
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_state_t;

    sync_state_t state;
    sync_state_t next_state;

    always_comb begin
        next_state.first  = async_in;
        next_state.second = state.first;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign sync_out = state.second;
endmodule : sync_two_flop

// *** sticky_bank.sv ***
// one sticky write-one-to-clear status word plus its sticky mask word
module sticky_bank #(
    parameter logic [31:0] STATUS_BITS = 32'h00000000,
    parameter logic [31:0] MASK_WR     = 32'h00000000,
    parameter logic [31:0] MASK_RESET  = 32'h00000000
) (
    input  wire logic        pclk,
    input  wire logic        sticky_resetn,
    input  wire logic        soft_reset,
    input  wire logic [31:0] events,
    input  wire logic        mask_we,
    input  wire logic        status_we,
    input  wire logic [31:0] wdata,
    output logic      [31:0] status,
    output logic      [31:0] mask,
    output logic             forward
);
    typedef struct packed {
        logic [31:0] status;
        logic [31:0] mask;
        logic        forward;
    } bank_state_t;

    bank_state_t state;
    bank_state_t next_state;
    logic        soft_unused;

    // soft reset deliberately leaves every field alone
    assign soft_unused = soft_reset;

    always_comb begin
        next_state = state;
        if (mask_we) begin
            // reserved mask bits keep their reset value, so their errors stay suppressed
            next_state.mask = (wdata & MASK_WR) | (MASK_RESET & ~MASK_WR);
        end
        // set beats clear in the same cycle
        next_state.status = ((state.status & ~(status_we ? wdata : 32'h00000000)) | events) & STATUS_BITS;
        // a one in the mask suppresses forwarding
        next_state.forward = |(events & STATUS_BITS & ~state.mask);
    end

    always_ff @(posedge pclk or negedge sticky_resetn) begin
        if (!sticky_resetn) begin
            state.status  <= 32'h00000000;
            state.mask    <= MASK_RESET;
            state.forward <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    assign status  = state.status;
    assign mask    = state.mask;
    assign forward = state.forward;
endmodule : sticky_bank

// *** internal_error_mask_status_monitor.sv ***
module internal_error_mask_status_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        rx_overflow_err,
    input wire logic        cfg_to_tx_parity_err,
    input wire logic        tx_to_cfg_parity_err,
    input wire logic        tx_tlp_parity_err,
    input wire logic        app_uncor_err,
    input wire logic        config_load_error_flag,
    input wire logic        lcrc_parity_err,
    input wire logic        rx_to_cfg_parity_err,
    input wire logic        rx_buf_in_parity_err,
    input wire logic        retry_uncor_ecc_err,
    input wire logic        rx_buf_uncor_ecc_err,
    input wire logic        app_cor_err,
    input wire logic        retry_cor_ecc_err,
    input wire logic        rx_buf_cor_ecc_err,
    input wire logic        tx_tlp_valid,
    input wire logic        tx_tlp_send,
    input wire logic        uncor_internal_err,
    input wire logic        cor_internal_err
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [2:0] age;
    wire logic  uncor_any = rx_overflow_err | cfg_to_tx_parity_err | tx_to_cfg_parity_err | tx_tlp_parity_err
        | app_uncor_err | config_load_error_flag | lcrc_parity_err | rx_to_cfg_parity_err
        | rx_buf_in_parity_err | retry_uncor_ecc_err | rx_buf_uncor_ecc_err;
    wire logic  cor_any = app_cor_err | config_load_error_flag | retry_cor_ecc_err | rx_buf_cor_ecc_err;
    // synchroniser history is only trustworthy once it has refilled after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) age <= 3'h0;
        else if (age != 3'h7) age <= age + 3'h1;
    end
    sequence apb_setup;
        psel && !penable;
    endsequence
    sequence apb_taken;
        psel && penable && !pready;
    endsequence
    answer_time_a: assert property (apb_setup ##1 apb_taken |=> pready)
        else $error("pready not one cycle after access");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held too long");
    slverr_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    write_rdata_a: assert property (pready && pwrite |-> prdata == 32'h00000000)
        else $error("write returned data");
    tlp_drop_a: assert property (tx_tlp_send |-> $past(tx_tlp_valid, 3) && !$past(tx_tlp_parity_err, 3))
        else $error("tlp sent despite parity");
    tlp_pass_a: assert property (age == 3'h7 && $past(tx_tlp_valid, 3) && !$past(tx_tlp_parity_err, 3)
        |-> tx_tlp_send)
        else $error("clean tlp not sent");
    // forward passes sync, bank and output flops: one stage more than the tlp path
    uncor_cause_a: assert property (uncor_internal_err |-> $past(uncor_any, 4))
        else $error("uncorrectable forward without error");
    cor_cause_a: assert property (cor_internal_err |-> $past(cor_any, 4))
        else $error("correctable forward without error");
endmodule : internal_error_mask_status_monitor

bind internal_error_mask_status internal_error_mask_status_monitor mon_u (.*);

// *** testbench.sv ***
`include "interr_consts.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk, presetn, soft_reset, psel, penable, pwrite, pready, pslverr, irq, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, um, cm, eu, ec;
    logic        tx_tlp_send, config_via_link_mode, uncor_internal_err, cor_internal_err, tx_tlp_valid;
    logic        rx_overflow_err, cfg_to_tx_parity_err, tx_to_cfg_parity_err, tx_tlp_parity_err;
    logic        app_uncor_err, config_load_error_flag, lcrc_parity_err, rx_to_cfg_parity_err;
    logic        rx_buf_in_parity_err, retry_uncor_ecc_err, rx_buf_uncor_ecc_err;
    logic        app_cor_err, retry_cor_ecc_err, rx_buf_cor_ecc_err;
    logic [1:0]  irq_seen;
    int          error_cnt, check_count, nu, nc;
    int          ub[11] = '{11, 9, 8, 7, 6, 5, 4, 3, 2, 1, 0};
    int          cb[3] = '{6, 1, 0};

    internal_error_mask_status dut_u (.*);

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        if (uncor_internal_err === 1'b1) nu++;
        if (cor_internal_err === 1'b1) nc++;
    end

    function automatic logic [31:0] ue(int i);
        ue = 32'h0;
        if (i < 11) ue[ub[i]] = 1'b1;
    endfunction : ue

    function automatic logic [31:0] ce(int i);
        ce = 32'h0;
        if (i > 10) ce[cb[i-11]] = 1'b1;
        if (i == 5) ce[5] = 1'b1;
    endfunction : ce

    task stop_test;
        if (error_cnt == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test

    task chk(input string n, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", n, exp, got);
        end
    endtask : chk

    task set_ev(input logic [13:0] v);
        {rx_overflow_err, cfg_to_tx_parity_err, tx_to_cfg_parity_err, tx_tlp_parity_err, app_uncor_err,
         config_load_error_flag, lcrc_parity_err, rx_to_cfg_parity_err, rx_buf_in_parity_err,
         retry_uncor_ecc_err, rx_buf_uncor_ecc_err, app_cor_err, retry_cor_ecc_err, rx_buf_cor_ecc_err} <= v;
    endtask : set_ev

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rchk(input string n, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(n, exp, rd);
    endtask : rchk

    // one-cycle event; five edges cover the second sync flop, the bank flops, the output flop and the count
    task pulse(input int i);
        set_ev(14'h1 << (13 - i));
        @(posedge pclk);
        set_ev(14'h0);
        repeat (5) @(posedge pclk);
    endtask : pulse

    task masks_ok;
        rchk("umask", `OFS_UNCOR_MASK, (um & `UNCOR_WR_BITS) | `UNCOR_MASK_RO_ONES);
        rchk("cmask", `OFS_COR_MASK, (cm & `COR_WR_BITS) | `COR_MASK_RO_ONES);
    endtask : masks_ok

    initial begin
        {psel, penable, pwrite, soft_reset, tx_tlp_valid, presetn} = 6'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        irq_seen = 2'h0;
        set_ev(14'h0);
        void'($urandom(74));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        um = `UNCOR_MASK_RESET;
        cm = `COR_MASK_RESET;
        masks_ok();
        rchk("ustat", `OFS_UNCOR_STATUS, 32'h0);
        rchk("cstat", `OFS_COR_STATUS, 32'h0);
        apb(1'b1, 12'hFFC, 32'hFFFFFFFF);
        chk("slverr", 32'h1, 32'(er));
        rchk("unmapped", 12'h01C, 32'h0);
        repeat (4) begin
            um = $urandom;
            cm = $urandom;
            apb(1'b1, `OFS_UNCOR_MASK, um);
            apb(1'b1, `OFS_COR_MASK, cm);
            masks_ok();
        end
        soft_reset <= 1'b1;
        repeat (3) @(posedge pclk);
        soft_reset <= 1'b0;
        masks_ok();
        pulse(5);
        rchk("ustat", `OFS_UNCOR_STATUS, 32'h0);
        rchk("cstat", `OFS_COR_STATUS, 32'h0);
        apb(1'b1, `OFS_LINK_MODE_CTRL, 32'h1);
        chk("mode", 32'h1, 32'(config_via_link_mode));
        tx_tlp_valid <= 1'b1;
        for (int r = 0; r < 2; r++) begin
            um = (r == 0) ? 32'h0 : $urandom;
            cm = (r == 0) ? 32'h0 : $urandom;
            apb(1'b1, `OFS_UNCOR_MASK, um);
            apb(1'b1, `OFS_COR_MASK, cm);
            um = (um & `UNCOR_WR_BITS) | `UNCOR_MASK_RO_ONES;
            cm = (cm & `COR_WR_BITS) | `COR_MASK_RO_ONES;
            for (int i = 0; i < 14; i++) begin
                nu = 0;
                nc = 0;
                eu = ue(i);
                ec = ce(i);
                pulse(i);
                rchk("ustat", `OFS_UNCOR_STATUS, eu);
                rchk("cstat", `OFS_COR_STATUS, ec);
                chk("ufwd", 32'(|(eu & ~um)), 32'(nu));
                chk("cfwd", 32'(|(ec & ~cm)), 32'(nc));
                irq_seen |= {|(ec & ~cm), |(eu & ~um)};
                apb(1'b1, `OFS_UNCOR_STATUS, eu);
                apb(1'b1, `OFS_COR_STATUS, ec);
                rchk("ustat", `OFS_UNCOR_STATUS, 32'h0);
                rchk("cstat", `OFS_COR_STATUS, 32'h0);
            end
        end
        // held flag: uncorrectable bit must not re-arm, correctable bit keeps setting
        config_load_error_flag <= 1'b1;
        repeat (5) @(posedge pclk);
        apb(1'b1, `OFS_UNCOR_STATUS, 32'hFFFFFFFF);
        apb(1'b1, `OFS_COR_STATUS, 32'hFFFFFFFF);
        rchk("ustat", `OFS_UNCOR_STATUS, 32'h0);
        rchk("cstat", `OFS_COR_STATUS, 32'h1 << `COR_BIT_CFGLOAD);
        config_load_error_flag <= 1'b0;
        tx_tlp_valid <= 1'b0;
        rchk("irqstat", `OFS_IRQ_STATUS, 32'(irq_seen));
        chk("irq", 32'h0, 32'(irq));
        apb(1'b1, `OFS_IRQ_MASK, 32'h3);
        @(posedge pclk);
        chk("irq", 32'h1, 32'(irq));
        apb(1'b1, `OFS_IRQ_STATUS, 32'h3);
        @(posedge pclk);
        chk("irq", 32'h0, 32'(irq));
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        um = `UNCOR_MASK_RESET;
        cm = `COR_MASK_RESET;
        masks_ok();
        stop_test();
    end

    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        stop_test();
    end
endmodule : testbench
